// ### phy_link_params.svh
`ifndef PHY_LINK_PARAMS_SVH
`define PHY_LINK_PARAMS_SVH

// ****************************************
// Register offsets
// ****************************************
`define PL_OFS_REQ      8'h00
`define PL_OFS_TX       8'h04
`define PL_OFS_STAT     8'h08

// ****************************************
// Register fields
// ****************************************
`define PL_F_TYPE       2:0
`define PL_F_SPEED      5:4
`define PL_F_ADDR       11:8
`define PL_F_WDATA      23:16
`define PL_F_TXCTL      1:0
`define PL_F_TXDATA     15:8
`define PL_B_BUSY       0
`define PL_B_OWNED      1
`define PL_B_LOST       2

// ****************************************
// Request stream
// ****************************************
`define PL_FRAME_W      17
`define PL_LEN_BUS      5'h07
`define PL_LEN_RD       5'h09
`define PL_LEN_WR       5'h11
`define PL_RT_TAKE      3'h0
`define PL_RT_ISO       3'h1
`define PL_RT_PRI       3'h2
`define PL_RT_FAIR      3'h3
`define PL_RT_RD        3'h4
`define PL_RT_WR        3'h5
`define PL_SPD_100      2'h0
`define PL_SPD_200      2'h1
`define PL_SPD_400      2'h2
`define PL_SPD_RSV      2'h3

// ****************************************
// Control pair codes
// ****************************************
`define PL_PHY_IDLE     2'h0
`define PL_PHY_STATUS   2'h1
`define PL_PHY_RECV     2'h2
`define PL_PHY_GRANT    2'h3
`define PL_LNK_IDLE     2'h0
`define PL_LNK_HOLD     2'h1
`define PL_LNK_XMIT     2'h2
`define PL_LNK_RSV      2'h3

// ****************************************
// Data width masks
// ****************************************
`define PL_MASK_100     8'h03
`define PL_MASK_200     8'h0F
`define PL_MASK_400     8'hFF

`endif

// ### phy_link_pkg.sv
package phy_link_pkg;

   typedef enum logic [1:0] {L_IDLE, L_WAIT_IDLE, L_SHIFT, L_WAIT_GRANT} link_state_t;

   typedef struct packed {
      logic       is_tx;
      logic [2:0] rtype;
      logic [1:0] speed;
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [1:0] tx_ctl;
      logic [7:0] tx_data;
   } link_cmd_t;

endpackage

// ### phy_link_interface_link_side.sv
`timescale 1ns/1ns
`include "phy_link_params.svh"

// Notes on behaviour
// R1 - Only requests start from the link; status, transmit and receive are started by the physical layer.
// R2 - The physical layer signals idle 00, status 01, receive 10 and grant 11 while it owns the pair.
// R3 - When owning the bus the link drives 00 to release, 01 to hold, 10 to transmit, and never 11.
// R4 - The physical layer keeps every shared line until it explicitly grants them to the link.
// R5 - The link keeps its data and control drivers off until a grant has been seen.
// R6 - Every link-started activity, bus requests and register accesses alike, goes out on the request line.
// R7 - Each request stream starts with a 1 bit and ends with a 0 bit.
// R8 - Streams are 7 bits for bus requests, 9 for register reads and 17 for register writes.
// R9 - A bus request carries start, type in bits 1-3, speed in bits 4-5 and stop in bit 6.
// R10 - A register read carries start, type in bits 1-3, address in bits 4-7 and stop in bit 8.
// R11 - The driven data width is 2, 4 or 8 lines for 100, 200 or 400 Mbit/s.
// R12 - Control width and interface clock do not change with speed.
// R13 - Request types are 000 take, 001 isochronous, 010 priority, 011 fair, 100 read, 101 write.
// R14 - Speed codes are 00 for 100, 01 for 200 and 10 for 400 Mbit/s, 11 reserved.
// R15 - A register write carries address in bits 4-7, data in bits 8-15 and stop in bit 16.
// R16 - Fair and priority requests start at least a clock after idle and restart after idle when receive is seen.
// R17 - Request bits go out one per interface clock, start bit first, and the line idles low.
module phy_link_interface_link_side (
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        phy_clk,
   output logic             link_request_line,
   input  wire logic        phy_control_line_a_i,
   input  wire logic        phy_control_line_b_i,
   output logic             phy_control_line_a_o,
   output logic             phy_control_line_b_o,
   output logic             phy_control_line_a_oe,
   output logic             phy_control_line_b_oe,
   input  wire logic [7:0]  phy_data_lines_i,
   output logic      [7:0]  phy_data_lines_o,
   output logic      [7:0]  phy_data_lines_oe
);

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [`PL_FRAME_W-1:0] build_frame(input phy_link_pkg::link_cmd_t c);
      logic [`PL_FRAME_W-1:0] f;
      f = '0;
      f[0] = 1'b1;
      f[3:1] = c.rtype;
      if (c.rtype == `PL_RT_RD) begin
         f[7:4] = c.addr;
      end else if (c.rtype == `PL_RT_WR) begin
         f[7:4]  = c.addr;
         f[15:8] = c.wdata;
      end else begin
         f[5:4] = c.speed;
      end
      return f;
   endfunction

   function automatic logic [4:0] frame_len(input logic [2:0] t);
      logic [4:0] n;
      n = `PL_LEN_BUS;
      if (t == `PL_RT_RD) n = `PL_LEN_RD;
      if (t == `PL_RT_WR) n = `PL_LEN_WR;
      return n;
   endfunction

   // Only data width follows speed; control pair stays two lines
   function automatic logic [7:0] width_mask(input logic [1:0] s); // see R12
      logic [7:0] m;
      m = `PL_MASK_100;
      if (s == `PL_SPD_200) m = `PL_MASK_200;
      if (s == `PL_SPD_400) m = `PL_MASK_400;
      return m;
   endfunction

   // ****************************************
   // Core domain: APB slave
   // ****************************************
   phy_link_pkg::link_cmd_t cmd_r;
   logic        cmd_tgl_r;
   logic        ack_s1_r;
   logic        ack_s2_r;
   logic        own_s1_r;
   logic        own_s2_r;
   logic        lost_s1_r;
   logic        lost_s2_r;
   logic        lost_s3_r;
   logic        lost_r;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        busy;
   logic        setup;
   logic        access;
   logic        bad;

   assign busy   = cmd_tgl_r ^ ack_s2_r;
   assign setup  = psel & ~penable;
   assign access = psel & penable & pready_r;

   always_comb begin
      bad = 1'b1;
      case (paddr)
         `PL_OFS_REQ: begin
            bad = pwrite & (busy | (pwdata[2] & pwdata[1])
                  | (pwdata[2] == 1'b0 && pwdata[`PL_F_SPEED] == `PL_SPD_RSV)); // see R13 see R14
         end
         `PL_OFS_TX:   bad = pwrite & (busy | pwdata[`PL_F_TXCTL] == `PL_LNK_RSV); // see R3
         `PL_OFS_STAT: bad = 1'b0;
         default:      bad = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end else begin
         pready_r  <= setup;
         pslverr_r <= setup & bad;
         if (setup) begin
            case (paddr)
               `PL_OFS_REQ:  prdata_r <= {8'h00, cmd_r.wdata, 4'h0, cmd_r.addr, 2'h0, cmd_r.speed, 1'b0, cmd_r.rtype};
               `PL_OFS_TX:   prdata_r <= {16'h0000, cmd_r.tx_data, 6'h00, cmd_r.tx_ctl};
               `PL_OFS_STAT: prdata_r <= {29'h0, lost_r, own_s2_r, busy};
               default:      prdata_r <= 32'h0;
            endcase
         end
      end
   end

   // Command word held stable until the link domain acknowledges
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cmd_r     <= '0;
         cmd_tgl_r <= 1'b0;
      end else if (access && pwrite && !pslverr_r) begin
         if (paddr == `PL_OFS_REQ) begin
            cmd_r.is_tx <= 1'b0;
            cmd_r.rtype <= pwdata[`PL_F_TYPE];
            cmd_r.speed <= pwdata[`PL_F_SPEED];
            cmd_r.addr  <= pwdata[`PL_F_ADDR];
            cmd_r.wdata <= pwdata[`PL_F_WDATA];
            cmd_tgl_r   <= ~cmd_tgl_r; // see R6
         end else if (paddr == `PL_OFS_TX) begin
            cmd_r.is_tx   <= 1'b1;
            cmd_r.tx_ctl  <= pwdata[`PL_F_TXCTL];
            cmd_r.tx_data <= pwdata[`PL_F_TXDATA];
            cmd_tgl_r     <= ~cmd_tgl_r;
         end
      end
   end

   // Lost flag: new event wins over a software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lost_r <= 1'b0;
      end else if (lost_s2_r ^ lost_s3_r) begin
         lost_r <= 1'b1;
      end else if (access && pwrite && paddr == `PL_OFS_STAT && pwdata[`PL_B_LOST]) begin
         lost_r <= 1'b0;
      end
   end

   // ****************************************
   // Link to core crossings
   // ****************************************
   logic ack_tgl_r;
   logic lost_tgl_r;
   logic own_r;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ack_s1_r  <= 1'b0;
         ack_s2_r  <= 1'b0;
         own_s1_r  <= 1'b0;
         own_s2_r  <= 1'b0;
         lost_s1_r <= 1'b0;
         lost_s2_r <= 1'b0;
         lost_s3_r <= 1'b0;
      end else begin
         ack_s1_r  <= ack_tgl_r;
         ack_s2_r  <= ack_s1_r;
         own_s1_r  <= own_r;
         own_s2_r  <= own_s1_r;
         lost_s1_r <= lost_tgl_r;
         lost_s2_r <= lost_s1_r;
         lost_s3_r <= lost_s2_r;
      end
   end

   // ****************************************
   // Link domain: reset and command sync
   // ****************************************
   logic lrst_s1_r;
   logic link_rst_n;
   logic req_s1_r;
   logic req_s2_r;
   logic req_s3_r;
   logic cmd_ev;
   logic [1:0] ctl_now;

   always_ff @(posedge phy_clk) begin
      lrst_s1_r  <= rst_n;
      link_rst_n <= lrst_s1_r;
   end

   always_ff @(posedge phy_clk) begin
      if (!link_rst_n) begin
         req_s1_r <= 1'b0;
         req_s2_r <= 1'b0;
         req_s3_r <= 1'b0;
      end else begin
         req_s1_r <= cmd_tgl_r;
         req_s2_r <= req_s1_r;
         req_s3_r <= req_s2_r;
      end
   end

   assign cmd_ev  = req_s2_r ^ req_s3_r; // see R1
   assign ctl_now = {phy_control_line_a_i, phy_control_line_b_i}; // see R2

   // ****************************************
   // Request serialiser
   // ****************************************
   phy_link_pkg::link_state_t st_r;
   logic [`PL_FRAME_W-1:0]    frame_r;
   logic [4:0]                len_r;
   logic [4:0]                cnt_r;
   logic                      arb_r;
   logic                      idle_seen_r;
   logic [1:0]                spd_r;
   logic                      link_request_line_r;

   always_ff @(posedge phy_clk) begin
      if (!link_rst_n) begin
         st_r        <= phy_link_pkg::L_IDLE;
         frame_r     <= '0;
         len_r       <= 5'h00;
         cnt_r       <= 5'h00;
         arb_r       <= 1'b0;
         idle_seen_r <= 1'b0;
         spd_r       <= `PL_SPD_100;
         ack_tgl_r   <= 1'b0;
         lost_tgl_r  <= 1'b0;
      end else begin
         idle_seen_r <= (ctl_now == `PL_PHY_IDLE);
         case (st_r)
            phy_link_pkg::L_IDLE: begin
               if (cmd_ev && cmd_r.is_tx) begin
                  ack_tgl_r <= ~ack_tgl_r;
               end else if (cmd_ev) begin
                  frame_r <= build_frame(cmd_r);         // see R9 see R10 see R15
                  len_r   <= frame_len(cmd_r.rtype);    // see R8
                  cnt_r   <= 5'h00;
                  arb_r   <= (cmd_r.rtype == `PL_RT_FAIR) || (cmd_r.rtype == `PL_RT_PRI);
                  if (!cmd_r.rtype[2]) begin
                     spd_r <= cmd_r.speed;
                  end
                  if ((cmd_r.rtype == `PL_RT_FAIR) || (cmd_r.rtype == `PL_RT_PRI)) begin
                     st_r <= phy_link_pkg::L_WAIT_IDLE; // see R16
                  end else begin
                     st_r <= phy_link_pkg::L_SHIFT;
                  end
               end
            end
            phy_link_pkg::L_WAIT_IDLE: begin
               if (idle_seen_r) begin
                  cnt_r <= 5'h00;
                  st_r  <= phy_link_pkg::L_SHIFT; // see R16
               end
            end
            phy_link_pkg::L_SHIFT: begin
               if (arb_r && ctl_now == `PL_PHY_RECV) begin
                  lost_tgl_r <= ~lost_tgl_r;
                  st_r       <= phy_link_pkg::L_WAIT_IDLE; // see R16
               end else if (cnt_r == len_r - 5'h01) begin
                  if (arb_r) begin
                     st_r <= phy_link_pkg::L_WAIT_GRANT;
                  end else begin
                     ack_tgl_r <= ~ack_tgl_r;
                     st_r      <= phy_link_pkg::L_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + 5'h01; // see R17
               end
            end
            phy_link_pkg::L_WAIT_GRANT: begin
               if (ctl_now == `PL_PHY_GRANT) begin
                  ack_tgl_r <= ~ack_tgl_r;
                  st_r      <= phy_link_pkg::L_IDLE;
               end else if (ctl_now == `PL_PHY_RECV) begin
                  lost_tgl_r <= ~lost_tgl_r;
                  st_r       <= phy_link_pkg::L_WAIT_IDLE; // see R16
               end
            end
            default: st_r <= phy_link_pkg::L_IDLE;
         endcase
      end
   end

   // Line stays low outside a stream
   always_ff @(posedge phy_clk) begin
      if (!link_rst_n) begin
         link_request_line_r <= 1'b0;
      end else begin
         link_request_line_r <= (st_r == phy_link_pkg::L_SHIFT) ? frame_r[cnt_r] : 1'b0; // see R7 see R17
      end
   end

   // ****************************************
   // Bus ownership and drivers
   // ****************************************
   logic [1:0] tx_ctl_r;
   logic [7:0] tx_data_r;
   logic [1:0] ctl_out_r;
   logic       ctl_oe_r;
   logic [7:0] data_out_r;
   logic [7:0] data_oe_r;

   always_ff @(posedge phy_clk) begin
      if (!link_rst_n) begin
         own_r      <= 1'b0;
         tx_ctl_r   <= `PL_LNK_HOLD;
         tx_data_r  <= 8'h00;
         ctl_out_r  <= `PL_LNK_IDLE;
         ctl_oe_r   <= 1'b0;
         data_out_r <= 8'h00;
         data_oe_r  <= 8'h00;
      end else begin
         if (cmd_ev && cmd_r.is_tx && st_r == phy_link_pkg::L_IDLE && cmd_r.tx_ctl != `PL_LNK_RSV) begin
            tx_ctl_r  <= cmd_r.tx_ctl;
            tx_data_r <= cmd_r.tx_data;
         end
         if (!own_r) begin
            if (ctl_now == `PL_PHY_GRANT) begin
               own_r      <= 1'b1; // see R4 see R5
               ctl_oe_r   <= 1'b1;
               ctl_out_r  <= tx_ctl_r;
               data_oe_r  <= width_mask(spd_r); // see R11
               data_out_r <= tx_data_r & width_mask(spd_r);
            end
         end else if (ctl_out_r == `PL_LNK_IDLE) begin
            own_r     <= 1'b0;
            ctl_oe_r  <= 1'b0;
            data_oe_r <= 8'h00;
            tx_ctl_r  <= `PL_LNK_HOLD;
         end else begin
            ctl_out_r  <= (tx_ctl_r == `PL_LNK_RSV) ? `PL_LNK_HOLD : tx_ctl_r; // see R3
            data_out_r <= tx_data_r & width_mask(spd_r);
         end
      end
   end

   assign prdata                = prdata_r;
   assign pready                = pready_r;
   assign pslverr               = pslverr_r;
   assign link_request_line     = link_request_line_r;
   assign phy_control_line_a_o  = ctl_out_r[1];
   assign phy_control_line_b_o  = ctl_out_r[0];
   assign phy_control_line_a_oe = ctl_oe_r;
   assign phy_control_line_b_oe = ctl_oe_r;
   assign phy_data_lines_o      = data_out_r;
   assign phy_data_lines_oe     = data_oe_r;

   // ****************************************
   // Assertions
   // ****************************************
   property p_start_bit;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r == phy_link_pkg::L_SHIFT && cnt_r == 5'h00) |=> link_request_line_r;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("stream did not open with 1"); // see R7

   property p_stop_bit;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r == phy_link_pkg::L_SHIFT && cnt_r == len_r - 5'h01) |=> !link_request_line_r;
   endproperty
   a_stop_bit: assert property (p_stop_bit) else $error("stream did not close with 0"); // see R7

   property p_len_bus;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r == phy_link_pkg::L_SHIFT && cnt_r == 5'h00 && len_r == `PL_LEN_BUS && !arb_r)
         |-> (st_r == phy_link_pkg::L_SHIFT) [*7] ##1 (st_r != phy_link_pkg::L_SHIFT);
   endproperty
   a_len_bus: assert property (p_len_bus) else $error("bus request length wrong"); // see R8

   property p_len_read;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r == phy_link_pkg::L_SHIFT && cnt_r == 5'h08 && len_r == `PL_LEN_RD) |=> st_r != phy_link_pkg::L_SHIFT;
   endproperty
   a_len_read: assert property (p_len_read) else $error("read request length wrong"); // see R8

   property p_grant_first;
      @(posedge phy_clk) disable iff (!link_rst_n)
      $rose(ctl_oe_r) |-> $past(ctl_now) == `PL_PHY_GRANT && data_oe_r != 8'h00;
   endproperty
   a_grant_first: assert property (p_grant_first) else $error("drivers on without grant"); // see R5

   property p_no_rsv;
      @(posedge phy_clk) disable iff (!link_rst_n)
      ctl_oe_r |-> ctl_out_r != `PL_LNK_RSV;
   endproperty
   a_no_rsv: assert property (p_no_rsv) else $error("reserved control code driven"); // see R3

   property p_width;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (data_oe_r != 8'h00) |-> (data_oe_r == width_mask(spd_r)) && ctl_oe_r;
   endproperty
   a_width: assert property (p_width) else $error("data width does not match speed"); // see R11

   property p_lost;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r == phy_link_pkg::L_WAIT_GRANT && ctl_now == `PL_PHY_RECV)
         |=> st_r == phy_link_pkg::L_WAIT_IDLE && $changed(lost_tgl_r);
   endproperty
   a_lost: assert property (p_lost) else $error("lost request not reissued"); // see R16

   property p_quiet;
      @(posedge phy_clk) disable iff (!link_rst_n)
      (st_r != phy_link_pkg::L_SHIFT) |=> !link_request_line_r;
   endproperty
   a_quiet: assert property (p_quiet) else $error("request line high outside stream"); // see R17

   c_granted: cover property (@(posedge phy_clk) disable iff (!link_rst_n)
      st_r == phy_link_pkg::L_WAIT_GRANT ##1 own_r);
   c_write_req: cover property (@(posedge phy_clk) disable iff (!link_rst_n)
      st_r == phy_link_pkg::L_SHIFT && len_r == `PL_LEN_WR && cnt_r == 5'h10);
   c_lost: cover property (@(posedge phy_clk) disable iff (!link_rst_n)
      st_r == phy_link_pkg::L_WAIT_GRANT && ctl_now == `PL_PHY_RECV);

endmodule

// ### phy_model.sv
`timescale 1ns/1ns
module phy_model (
   input  wire logic        phy_clk,
   input  wire logic [1:0]  want_code,
   input  wire logic        link_request_line,
   input  wire logic        a_o,
   input  wire logic        b_o,
   input  wire logic        a_oe,
   input  wire logic        b_oe,
   input  wire logic [7:0]  d_o,
   input  wire logic [7:0]  d_oe,
   output logic             ctl_a,
   output logic             ctl_b,
   output logic      [7:0]  data,
   output logic             frm_done,
   output logic      [21:0] frm
);
   logic [1:0]  code_r = 2'h0;
   logic [7:0]  pat_r = 8'hA5;
   logic [16:0] sr_r = 17'h0;
   logic [4:0]  cnt_r = 5'h0;
   logic [4:0]  len;

   // Phy drives the pair and data unless the link enables its drivers
   always_ff @(posedge phy_clk) begin
      code_r <= want_code;
      pat_r  <= ~pat_r;
   end
   assign ctl_a = a_oe ? a_o : code_r[1];
   assign ctl_b = b_oe ? b_o : code_r[0];
   assign data  = (d_oe & d_o) | (~d_oe & pat_r);

   // Request stream capture, length from the type field
   assign len = (sr_r[3:1] < 3'h4) ? 5'h07 : (sr_r[3:1] == 3'h4) ? 5'h09 : 5'h11;
   always_ff @(posedge phy_clk) begin
      frm_done <= 1'b0;
      if (cnt_r == 5'h0) begin
         if (link_request_line === 1'b1) begin
            sr_r  <= 17'h1;
            cnt_r <= 5'h1;
         end
      end else if (cnt_r == len) begin
         frm      <= {len, sr_r};
         frm_done <= 1'b1;
         cnt_r    <= 5'h0;
      end else begin
         sr_r[cnt_r] <= link_request_line;
         cnt_r       <= cnt_r + 5'h1;
      end
   end
endmodule

// ### tb.sv
`timescale 1ns/1ns
module tb;
   logic        core_clk;
   logic        phy_clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        link_request_line_line;
   logic        a_o, b_o, a_oe, b_oe, ctl_a, ctl_b;
   logic [7:0]  d_o, d_oe, data;
   logic [1:0]  want_code;
   logic        frm_done;
   logic [21:0] frm;
   logic [21:0] exp_q[$];
   int          n_mismatch;
   int          samples_checked;
   logic [31:0] rd;
   logic        err;

   phy_link_interface_link_side i_phy_link_interface_link_side (.core_clk(core_clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phy_clk(phy_clk), .link_request_line(link_request_line_line),
      .phy_control_line_a_i(ctl_a), .phy_control_line_b_i(ctl_b), .phy_control_line_a_o(a_o),
      .phy_control_line_b_o(b_o), .phy_control_line_a_oe(a_oe), .phy_control_line_b_oe(b_oe),
      .phy_data_lines_i(data), .phy_data_lines_o(d_o), .phy_data_lines_oe(d_oe));
   phy_model i_phy_model (.phy_clk(phy_clk), .want_code(want_code), .link_request_line(link_request_line_line),
      .a_o(a_o), .b_o(b_o), .a_oe(a_oe), .b_oe(b_oe), .d_o(d_o), .d_oe(d_oe), .ctl_a(ctl_a),
      .ctl_b(ctl_b), .data(data), .frm_done(frm_done), .frm(frm));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      phy_clk = 1'b0;
      #3;
      forever begin
         #8 phy_clk = 1'b1;
         #7 phy_clk = 1'b0;
      end
   end

   // ****************************************
   // Checking and bus tasks
   // ****************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic hang();
      n_mismatch++;
      close_out();
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 16; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 16) hang();
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_for(ref logic sig, input logic v);
      int i;
      for (i = 0; i < 300 && sig !== v; i++) @(posedge core_clk);
      if (i == 300) hang();
   endtask
   task automatic wait_q();
      int i;
      for (i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge core_clk);
      if (i == 300) hang();
   endtask
   task automatic wait_free();
      int i;
      for (i = 0; i < 100; i++) begin
         apb(1'b0, 8'h08, 32'h00000000);
         if (rd[0] === 1'b0) break;
      end
      if (i == 100) hang();
   endtask
   task automatic req(input logic [2:0] t, input logic [1:0] s, input logic [3:0] ad, input logic [7:0] dt);
      logic [16:0] f;
      f = 17'h00001;
      f[3:1] = t;
      if (t < 3'h4) f[5:4] = s;
      else f[7:4] = ad;
      if (t == 3'h5) f[15:8] = dt;
      exp_q.push_back({(t < 3'h4) ? 5'h07 : (t == 3'h4) ? 5'h09 : 5'h11, f});
      apb(1'b1, 8'h00, {8'h00, dt, 4'h0, ad, 2'h0, s, 1'b0, t});
      chk("req_err", 32'h00000000, err);
   endtask
   task automatic own(input logic [1:0] s);
      logic [7:0] m;
      logic [7:0] dt;
      m  = (s == 2'h0) ? 8'h03 : (s == 2'h1) ? 8'h0F : 8'hFF;
      dt = 8'($urandom);
      want_code <= 2'h3;
      wait_for(a_oe, 1'b1);
      want_code <= 2'h0;
      chk("data_oe", m, d_oe);
      apb(1'b1, 8'h04, {16'h0000, dt, 8'h02});
      wait_for(ctl_a, 1'b1);
      chk("xmit_ctl", 32'h00000002, {ctl_a, ctl_b});
      chk("xmit_data", dt & m, data & m);
      apb(1'b1, 8'h04, 32'h00000000);
      wait_for(a_oe, 1'b0);
      chk("released", 32'h00000000, {a_oe, b_oe, d_oe});
      wait_free();
   endtask

   // Frames seen by the phy model, against the driver's notes
   always @(posedge phy_clk) begin
      if (frm_done === 1'b1) begin
         if (exp_q.size() == 0) chk("frame_extra", 32'h0, 32'h1);
         else chk("frame", exp_q.pop_front(), frm);
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int k;
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      want_code = 2'h0;
      n_mismatch = 0;
      samples_checked = 0;
      void'($urandom(20));
      repeat (3) @(posedge core_clk);
      chk("reset_out", 32'h0, {a_oe, b_oe, d_oe, link_request_line_line, pready});
      rst_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      for (k = 0; k < 8; k++) begin
         req(3'((k % 4 < 2) ? k % 4 : k % 4 + 2), 2'($urandom % 3), 4'($urandom), 8'($urandom));
         wait_free();
         wait_q();
         chk("no_grant_oe", 32'h0, {a_oe, b_oe, d_oe, link_request_line_line});
      end
      $display("test direct requests done");
      apb(1'b1, 8'h00, 32'h00000006);
      chk("rsv_type6", 32'h1, err);
      apb(1'b1, 8'h00, 32'h00000007);
      chk("rsv_type7", 32'h1, err);
      apb(1'b1, 8'h00, 32'h00000033);
      chk("rsv_speed", 32'h1, err);
      apb(1'b0, 8'h0C, 32'h00000000);
      chk("unmapped", 32'h1, err);
      req(3'h5, 2'h0, 4'hA, 8'h3C);
      apb(1'b1, 8'h00, 32'h00000004);
      chk("busy_refuse", 32'h1, err);
      wait_free();
      wait_q();
      apb(1'b0, 8'h00, 32'h00000000);
      chk("req_readback", 32'h003C0A05, rd);
      $display("test refusals done");
      for (k = 0; k < 3; k++) begin
         want_code <= 2'h1;
         req((k == 1) ? 3'h2 : 3'h3, 2'(k), 4'h0, 8'h00);
         repeat (20) @(posedge core_clk);
         chk("arb_held", 32'h1, exp_q.size());
         want_code <= 2'h0;
         wait_q();
         apb(1'b0, 8'h08, 32'h00000000);
         chk("busy_owned", 32'h1, rd[1:0]);
         own(2'(k));
      end
      $display("test grants done");
      req(3'h3, 2'h2, 4'h0, 8'h00);
      wait_q();
      exp_q.push_back(exp_q.size() == 0 ? {5'h07, 17'h00027} : 22'h0);
      want_code <= 2'h2;
      for (k = 0; k < 20; k++) begin
         apb(1'b0, 8'h08, 32'h00000000);
         if (rd[2] === 1'b1) break;
      end
      chk("lost", 32'h1, rd[2]);
      want_code <= 2'h0;
      wait_q();
      apb(1'b1, 8'h08, 32'h00000004);
      apb(1'b0, 8'h08, 32'h00000000);
      chk("lost_clear", 32'h0, rd[2]);
      own(2'h2);
      $display("test lost request done");
      close_out();
   end
endmodule
